// [include/fan_ctrl_params.svh]
// Purpose: offsets, field positions, reset values and timing counts of the fan speed block
// Assumes: 250 MHz core clock
// Notes: guarded against double inclusion
`ifndef FAN_CTRL_PARAMS_SVH
`define FAN_CTRL_PARAMS_SVH

`define CLK_MHZ 250
`define CLK_PERIOD_NS 4
// drain-source overcurrent persistence, ns
`define OC_PERSIST_NS 640
`define OC_PERSIST_CYC ((`OC_PERSIST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// register offsets (own choice)
`define REG_CURVE0 8'h00
`define REG_CURVE1 8'h04
`define REG_CURVE2 8'h08
`define REG_CURVE3 8'h0c
`define REG_PROT 8'h10
`define REG_STATUS 8'h14
`define REG_SPEED 8'h18
`define REG_ADC 8'h1c
`define REG_ID 8'h20
// field positions in REG_CURVE0
`define F_MINIMUM_SPEED_SETTING_LSB 0
`define F_INVERT_BIT 12
`define F_CLAMPOPT_BIT 14
`define F_ANALOG_BIT 15
`define F_SLOPE_LSB 16
// reset values
`define RST_MINIMUM_SPEED_SETTING 12'd2000
`define RST_SLOPE 14'd2243
`define RST_ENTHR 8'd97
`define RST_DISTHR 8'd79
`define RST_CLAMPOPT 1'b1
// demand arithmetic
`define DUTY_FULL 9'd511
`define ADC_OFFSET 10'd12
`define SLOPE_SHIFT 6
`define MAXCLAMP_STEP 3
// arbitrary identification value
`define ID_VALUE 32'h0000_5a01
`endif

// [include/fan_ctrl_pkg.sv]
// Purpose: types shared by the fan speed demand block
// Assumes: constants come from fan_ctrl_params.svh
// Notes: none
package fan_ctrl_pkg;
	typedef enum logic [2:0]
	{
		ST_STANDBY = 3'b000,
		ST_START = 3'b001,
		ST_RUN = 3'b010,
		ST_LOCKOFF = 3'b011,
		ST_COAST = 3'b100,
		ST_SHUTDOWN = 3'b101
	} drive_state_t;

	typedef struct packed
	{
		logic [11:0] min_speed;
		logic [13:0] slope;
		logic invert;
		logic clamp_opt;
		logic analog_mode;
		logic [7:0] en_thr;
		logic [7:0] dis_thr;
		logic [7:0] low_clamp;
		logic [3:0] high_clamp;
		logic [3:0] high_hys;
		logic [8:0] sw_duty;
		logic [15:0] sw_speed;
	} curve_cfg_t;

	typedef struct packed
	{
		logic [1:0] limit_level;
		logic limit_disable;
		logic recovery_sel;
		logic [23:0] lock_off_cyc;
		logic [23:0] coast_cyc;
		logic [3:0] pole_pairs;
		logic fault_disable;
	} prot_cfg_t;
endpackage

// [rtl/duty_meter.sv]
// Purpose: measures high time over period of the demand pwm into a 9-bit duty
// Assumes: input synchronous to CLK
// Notes: value refreshes once per completed period, at each rising edge
`include "fan_ctrl_params.svh"
module duty_meter
	import fan_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic pwm_in,
	output logic [8:0] duty,
	output logic period_done
);
	typedef struct packed
	{
		logic prev;
		logic [23:0] period;
		logic [23:0] high;
		logic [8:0] duty;
		logic done;
	} meter_t;
	meter_t s_reg;
	meter_t s_next;
	logic [32:0] scaled;
	always_comb
	begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.prev = pwm_in;
		scaled = 33'({9'd0, s_reg.high} * 33'(`DUTY_FULL));
		if (pwm_in && !s_reg.prev)
		begin
			if (s_reg.period != 24'd0)
			begin
				s_next.duty = 9'(scaled / 33'(s_reg.period)); // RULE24
			end
			s_next.done = 1'b1;
			s_next.period = 24'd1;
			s_next.high = 24'd1;
		end
		else
		begin
			if (s_reg.period != 24'hffffff)
			begin
				s_next.period = s_reg.period + 24'd1;
			end
			if (pwm_in && s_reg.high != 24'hffffff)
			begin
				s_next.high = s_reg.high + 24'd1;
			end
		end
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end
	assign duty = s_reg.duty;
	assign period_done = s_reg.done;
endmodule

// [rtl/fan_speed_demand_control.sv]
// Purpose: speed demand, curve and protection control of a sensorless fan driver
// Assumes: all inputs synchronous to CLK; analog converter delivers a raw code
// Notes: registers reached over a plain address/strobe port
// Contract
// RULE1: measure demand duty in logic into 9 bits, map through curve to target
// RULE2: standby when demand stays low past lock off-time, unless curve keeps minimum
// RULE3: tach output gives two periods per revolution, scaled by pole pairs; below four pole pairs the code toggles it on every electrical cycle
// RULE4: tach output is open drain shared with serial data; demand pin shared
// RULE5: fault output flags rotor fault, or end of start when disabled
// RULE6: select duty or analog; code is volts/4.82mV minus 12, limited 0..511
// RULE7: host keeps demand pwm between max(100Hz, 2.5x tach) and 100kHz
// RULE8: locked rotor switches drive off for lock off-time before restart
// RULE9: rotation sense 1 sequences A,B,C; 0 sequences A,C,B
// RULE10: sense change while running coasts, then restarts, resynchronizing if reversed
// RULE11: overcurrent lasting 640ns shuts drivers; recovery by pwm toggle or timeout
// RULE12: with limit enabled, sink overcurrent cuts source drivers for the pwm cycle
// RULE13: two-bit limit code selects 3.2, 2.6, 1.8 or 1 A
// RULE14: minimum speed setting 0..4095 rpm, 1 rpm resolution
// RULE15: target equals slope setting times duty over 64 plus minimum speed
// RULE16: eight-bit enable threshold on duty; zero runs motor at zero duty
// RULE17: eight-bit disable threshold stops drive when duty falls below it
// RULE18: invert bit mirrors the speed curve about input duty
// RULE19: duty below low clamp code ignored; code zero disables clamp
// RULE20: high clamp at 511 minus code times 8; option picks open or clamped
// RULE21: high clamp switching uses hysteresis of code plus one steps
// RULE22: nonzero slope switch duty joins two slopes at switch point
// RULE23: enable and disable thresholds act as a hysteresis pair
// RULE24: demand value updates once per completed input pwm period
`include "fan_ctrl_params.svh"
module fan_speed_demand_control
	import fan_ctrl_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD_STB,
	output logic [31:0] RDATA,
	input wire logic SPEED_DEMAND_INPUT,
	input wire logic [9:0] ADC_RAW,
	input wire logic ROTATION_SENSE,
	input wire logic ROTOR_LOCKED,
	input wire logic ROTOR_FAULT,
	input wire logic START_DONE,
	input wire logic REVERSE_SPIN,
	input wire logic ELEC_CYCLE,
	input wire logic DS_OVERCURRENT,
	input wire logic SINK_OVERCURRENT,
	input wire logic PWM_CYCLE_START,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	output logic SDA_IN,
	input wire logic SPEED_TACH_IN,
	output logic SPEED_TACH_OUTPUT_O,
	output logic SPEED_TACH_OUTPUT_OE,
	output logic ROTOR_FAULT_O,
	output logic ROTOR_FAULT_OE,
	output logic DRIVE_EN,
	output logic SOURCE_EN,
	output logic BRAKE_RESYNC,
	output logic [2:0] PHASE_ORDER,
	output logic [1:0] CURRENT_LIMIT_LEVEL,
	output logic [15:0] TARGET_SPEED
);
	typedef struct packed
	{
		curve_cfg_t curve;
		prot_cfg_t prot;
		drive_state_t st;
		logic [23:0] timer;
		logic [23:0] low_cnt;
		logic [7:0] oc_cnt;
		logic enabled;
		logic open_hi;
		logic src_cut;
		logic dir_q;
		logic pwm_q;
		logic tach;
		logic [3:0] pp_cnt;
		logic fault;
		logic [31:0] rdata;
		logic [8:0] demand;
	} top_t;
	top_t s_reg;
	top_t s_next;
	logic [8:0] meas_duty;
	logic meas_done;
	logic [8:0] adc_code;
	logic [8:0] demand_src;
	logic [15:0] curve_target;
	logic [8:0] eff_duty;
	logic [8:0] max_lvl;
	logic [8:0] hys;
	logic keeps_min;
	logic pwm_edge;
	duty_meter u_meter
	(
		.clk(CLK),
		.nrst(NRST),
		.pwm_in(SPEED_DEMAND_INPUT),
		.duty(meas_duty),
		.period_done(meas_done)
	);
	speed_curve u_curve
	(
		.clk(CLK),
		.nrst(NRST),
		.demand(s_reg.demand),
		.cfg(s_reg.curve),
		.open_loop_hi(s_reg.open_hi),
		.target(curve_target),
		.eff_duty(eff_duty)
	);
	always_comb
	begin
		// analog code: raw minus offset, limited to full scale
		if (ADC_RAW < `ADC_OFFSET)
		begin
			adc_code = 9'd0; // RULE6
		end
		else if (ADC_RAW - `ADC_OFFSET > 10'(`DUTY_FULL))
		begin
			adc_code = `DUTY_FULL; // RULE6
		end
		else
		begin
			adc_code = 9'(ADC_RAW - `ADC_OFFSET); // RULE6
		end
		demand_src = s_reg.curve.analog_mode ? adc_code : meas_duty; // RULE1
		max_lvl = `DUTY_FULL - 9'({s_reg.curve.high_clamp, 3'b000});
		hys = 9'({s_reg.curve.high_hys, 1'b0}) + 9'd2;
		keeps_min = (s_reg.curve.low_clamp != 8'd0) || (s_reg.curve.en_thr == 8'd0);
		pwm_edge = SPEED_DEMAND_INPUT && !s_reg.pwm_q;
	end
	always_comb
	begin
		s_next = s_reg;
		s_next.pwm_q = SPEED_DEMAND_INPUT;
		s_next.dir_q = ROTATION_SENSE;
		if (s_reg.curve.analog_mode || meas_done)
		begin
			s_next.demand = demand_src; // RULE24
		end
		if (!s_reg.enabled && s_reg.demand >= {1'b0, s_reg.curve.en_thr})
		begin
			s_next.enabled = 1'b1; // RULE16 RULE23
		end
		else if (s_reg.enabled && s_reg.demand < {1'b0, s_reg.curve.dis_thr}
			&& s_reg.curve.en_thr != 8'd0)
		begin
			s_next.enabled = 1'b0; // RULE17 RULE23
		end
		// open loop above the high clamp, with hysteresis
		if (s_reg.curve.high_clamp == 4'd0 || s_reg.curve.clamp_opt)
		begin
			s_next.open_hi = 1'b0;
		end
		else if (eff_duty >= max_lvl)
		begin
			s_next.open_hi = 1'b1; // RULE20
		end
		else if ({1'b0, eff_duty} + {1'b0, hys} < {1'b0, max_lvl})
		begin
			s_next.open_hi = 1'b0; // RULE21
		end
		if (SPEED_DEMAND_INPUT || s_reg.curve.analog_mode)
		begin
			s_next.low_cnt = 24'd0;
		end
		else if (s_reg.low_cnt != 24'hffffff)
		begin
			s_next.low_cnt = s_reg.low_cnt + 24'd1;
		end
		// overcurrent persistence
		if (DS_OVERCURRENT)
		begin
			if (s_reg.oc_cnt != 8'hff)
			begin
				s_next.oc_cnt = s_reg.oc_cnt + 8'd1;
			end
		end
		else
		begin
			s_next.oc_cnt = 8'd0;
		end
		// cycle by cycle limit
		if (PWM_CYCLE_START)
		begin
			s_next.src_cut = 1'b0;
		end
		if (SINK_OVERCURRENT && !s_reg.prot.limit_disable)
		begin
			s_next.src_cut = 1'b1; // RULE12
		end
		if (s_reg.timer != 24'd0)
		begin
			s_next.timer = s_reg.timer - 24'd1;
		end
		unique case (s_reg.st)
			ST_STANDBY:
			begin
				if (s_reg.enabled || keeps_min)
				begin
					s_next.st = ST_START;
				end
			end
			ST_START, ST_RUN:
			begin
				if (s_reg.st == ST_START && START_DONE)
				begin
					s_next.st = ST_RUN;
				end
				if (!s_reg.enabled && !keeps_min)
				begin
					s_next.st = ST_STANDBY;
				end
				if (!keeps_min && s_reg.low_cnt >= s_reg.prot.lock_off_cyc)
				begin
					s_next.st = ST_STANDBY; // RULE2
				end
				if (ROTOR_LOCKED)
				begin
					s_next.st = ST_LOCKOFF; // RULE8
					s_next.timer = s_reg.prot.lock_off_cyc;
				end
				if (ROTATION_SENSE != s_reg.dir_q)
				begin
					s_next.st = ST_COAST; // RULE10
					s_next.timer = s_reg.prot.coast_cyc;
				end
				if (s_reg.oc_cnt >= 8'(`OC_PERSIST_CYC))
				begin
					s_next.st = ST_SHUTDOWN; // RULE11
					s_next.timer = s_reg.prot.coast_cyc;
				end
			end
			ST_LOCKOFF, ST_COAST:
			begin
				if (s_reg.timer == 24'd0 && !(s_reg.st == ST_COAST && REVERSE_SPIN))
				begin
					s_next.st = ST_START; // RULE8 RULE10
				end
			end
			ST_SHUTDOWN:
			begin
				if (s_reg.prot.recovery_sel ? (s_reg.timer == 24'd0) : pwm_edge)
				begin
					s_next.st = ST_START; // RULE11
				end
			end
			default:
			begin
				s_next.st = ST_STANDBY;
			end
		endcase
		// four tach edges per pole pairs of electrical cycles; below four pairs one per cycle
		if (ELEC_CYCLE && s_reg.st == ST_RUN)
		begin
			if (5'(s_reg.pp_cnt) + 5'd4 >= {1'b0, s_reg.prot.pole_pairs})
			begin
				s_next.pp_cnt = (s_reg.prot.pole_pairs <= 4'd4) ? 4'd0
					: 4'(5'(s_reg.pp_cnt) + 5'd4 - {1'b0, s_reg.prot.pole_pairs});
				s_next.tach = !s_reg.tach; // RULE3
			end
			else
			begin
				s_next.pp_cnt = s_reg.pp_cnt + 4'd4;
			end
		end
		s_next.fault = s_reg.prot.fault_disable ? START_DONE : ROTOR_FAULT; // RULE5
		if (WR)
		begin
			unique case (ADDR)
				`REG_CURVE0:
				begin
					s_next.curve.min_speed = WDATA[`F_MINIMUM_SPEED_SETTING_LSB +: 12]; // RULE14
					s_next.curve.invert = WDATA[`F_INVERT_BIT];
					s_next.curve.clamp_opt = WDATA[`F_CLAMPOPT_BIT];
					s_next.curve.analog_mode = WDATA[`F_ANALOG_BIT];
					s_next.curve.slope = WDATA[`F_SLOPE_LSB +: 14];
				end
				`REG_CURVE1:
				begin
					s_next.curve.en_thr = WDATA[7:0];
					s_next.curve.dis_thr = WDATA[15:8];
					s_next.curve.low_clamp = WDATA[23:16];
					s_next.curve.high_clamp = WDATA[27:24];
					s_next.curve.high_hys = WDATA[31:28];
				end
				`REG_CURVE2:
				begin
					s_next.curve.sw_duty = WDATA[8:0];
					s_next.curve.sw_speed = WDATA[31:16];
				end
				`REG_CURVE3:
				begin
					s_next.prot.lock_off_cyc = WDATA[23:0];
				end
				`REG_PROT:
				begin
					s_next.prot.limit_level = WDATA[1:0]; // RULE13
					s_next.prot.limit_disable = WDATA[2];
					s_next.prot.recovery_sel = WDATA[3];
					s_next.prot.pole_pairs = WDATA[7:4];
					s_next.prot.fault_disable = WDATA[8];
					s_next.prot.coast_cyc = {1'b0, WDATA[31:9]};
				end
				default:
				begin
				end
			endcase
		end
		s_next.rdata = 32'h0000_0000;
		if (RD_STB)
		begin
			unique case (ADDR)
				`REG_CURVE0: s_next.rdata = {2'b00, s_reg.curve.slope, s_reg.curve.analog_mode,
					s_reg.curve.clamp_opt, 1'b0, s_reg.curve.invert, s_reg.curve.min_speed};
				`REG_CURVE1: s_next.rdata = {s_reg.curve.high_hys, s_reg.curve.high_clamp,
					s_reg.curve.low_clamp, s_reg.curve.dis_thr, s_reg.curve.en_thr};
				`REG_CURVE2: s_next.rdata = {s_reg.curve.sw_speed, 7'd0, s_reg.curve.sw_duty};
				`REG_CURVE3: s_next.rdata = {8'd0, s_reg.prot.lock_off_cyc};
				`REG_PROT: s_next.rdata = {s_reg.prot.coast_cyc[22:0], s_reg.prot.fault_disable,
					s_reg.prot.pole_pairs, s_reg.prot.recovery_sel, s_reg.prot.limit_disable,
					s_reg.prot.limit_level};
				`REG_STATUS: s_next.rdata = {16'd0, 2'd0, s_reg.demand, s_reg.open_hi,
					s_reg.enabled, s_reg.st};
				`REG_SPEED: s_next.rdata = {7'd0, eff_duty, curve_target};
				`REG_ADC: s_next.rdata = {23'd0, adc_code};
				`REG_ID: s_next.rdata = `ID_VALUE;
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			s_reg <= '0;
			s_reg.curve.min_speed <= `RST_MINIMUM_SPEED_SETTING;
			s_reg.curve.slope <= `RST_SLOPE;
			s_reg.curve.en_thr <= `RST_ENTHR;
			s_reg.curve.dis_thr <= `RST_DISTHR;
			s_reg.curve.clamp_opt <= `RST_CLAMPOPT;
			s_reg.prot.pole_pairs <= 4'd2;
			s_reg.prot.lock_off_cyc <= 24'd1000;
			s_reg.prot.coast_cyc <= 24'd1000;
			s_reg.dir_q <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end
	assign RDATA = s_reg.rdata;
	// open drain: drive low for serial data low while SDA_OE is set, otherwise for tach low
	assign SPEED_TACH_OUTPUT_O = 1'b0;
	assign SPEED_TACH_OUTPUT_OE = (SDA_OE && !SDA_OUT) || (!SDA_OE && !s_reg.tach); // RULE4
	assign SDA_IN = SPEED_TACH_IN; // RULE4
	assign ROTOR_FAULT_O = 1'b0;
	assign ROTOR_FAULT_OE = !s_reg.fault; // RULE5
	assign DRIVE_EN = (s_reg.st == ST_START) || (s_reg.st == ST_RUN);
	assign SOURCE_EN = DRIVE_EN && !s_reg.src_cut; // RULE12
	assign BRAKE_RESYNC = (s_reg.st == ST_COAST) && REVERSE_SPIN && s_reg.timer == 24'd0; // RULE10
	assign PHASE_ORDER = s_reg.dir_q ? 3'b001 : 3'b010; // RULE9
	assign CURRENT_LIMIT_LEVEL = s_reg.prot.limit_level; // RULE13
	assign TARGET_SPEED = s_reg.open_hi ? 16'hffff : curve_target; // RULE1
endmodule

// [rtl/speed_curve.sv]
// Purpose: maps 9-bit demand into a target speed in rpm
// Assumes: configuration stable while in use
// Notes: registered output, one cycle latency
`include "fan_ctrl_params.svh"
module speed_curve
	import fan_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [8:0] demand,
	input curve_cfg_t cfg,
	input wire logic open_loop_hi,
	output logic [15:0] target,
	output logic [8:0] eff_duty
);
	typedef struct packed
	{
		logic [15:0] target;
		logic [8:0] duty;
	} curve_t;
	curve_t s_reg;
	curve_t s_next;
	logic [8:0] d;
	logic [8:0] max_lvl;
	logic [31:0] acc;
	always_comb
	begin
		s_next = s_reg;
		d = cfg.invert ? (`DUTY_FULL - demand) : demand; // RULE18
		max_lvl = `DUTY_FULL - 9'({cfg.high_clamp, 3'b000});
		if (cfg.low_clamp != 8'd0 && d < {1'b0, cfg.low_clamp})
		begin
			d = {1'b0, cfg.low_clamp}; // RULE19
		end
		if (cfg.high_clamp != 4'd0 && d > max_lvl && !open_loop_hi)
		begin
			d = max_lvl; // RULE20
		end
		if (cfg.sw_duty != 9'd0 && d > cfg.sw_duty)
		begin
			acc = 32'(cfg.sw_speed) + 32'((32'(d - cfg.sw_duty) * 32'(cfg.slope))
				>> `SLOPE_SHIFT); // RULE22
		end
		else if (cfg.sw_duty != 9'd0)
		begin
			acc = 32'(cfg.min_speed) + 32'((32'(cfg.sw_speed - 16'(cfg.min_speed))
				* 32'(d)) / 32'(cfg.sw_duty)); // RULE22
		end
		else
		begin
			acc = 32'(cfg.min_speed) + ((32'(d) * 32'(cfg.slope)) >> `SLOPE_SHIFT); // RULE15 RULE14
		end
		s_next.target = (acc > 32'h0000ffff) ? 16'hffff : acc[15:0];
		s_next.duty = d;
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end
	assign target = s_reg.target;
	assign eff_duty = s_reg.duty;
endmodule

// [verification/demand_host.sv]
// Purpose: host model driving the demand pwm line
// Assumes: period and high time in clock cycles
// Notes: line stays low when high time is zero
module demand_host
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] high_cyc,
	input wire logic [15:0] period_cyc,
	output logic pwm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt <= 16'h0;
			pwm <= 1'b0;
		end
		else
		begin
			cnt <= (cnt >= period_cyc - 16'h1) ? 16'h0 : cnt + 16'h1;
			pwm <= cnt < high_cyc;
		end
	end
endmodule

// [verification/fan_ctrl_chk.sv]
// Purpose: port-level checks of the fan speed demand block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the top module
module fan_ctrl_chk
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic RD_STB,
	input wire logic [31:0] RDATA,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic SDA_IN,
	input wire logic SPEED_TACH_IN,
	input wire logic SPEED_TACH_OUTPUT_O,
	input wire logic SPEED_TACH_OUTPUT_OE,
	input wire logic ROTOR_FAULT_O,
	input wire logic DRIVE_EN,
	input wire logic SOURCE_EN,
	input wire logic DS_OVERCURRENT,
	input wire logic ROTOR_LOCKED,
	input wire logic [2:0] PHASE_ORDER
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] oc_cnt;
	// consecutive cycles of drain-source overcurrent, saturating
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			oc_cnt <= 8'h00;
		else if (!DS_OVERCURRENT)
			oc_cnt <= 8'h00;
		else if (oc_cnt != 8'hff)
			oc_cnt <= oc_cnt + 8'h01;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	rdata_idle_a: assert property (!$past(RD_STB) |-> RDATA == 32'h0)
		else $error("read data seen outside its cycle");
	sda_follow_a: assert property (SDA_IN == SPEED_TACH_IN)
		else $error("serial data input does not follow the shared pin");
	sda_drive_a: assert property (SDA_OE && !SDA_OUT |-> ##[0:1] SPEED_TACH_OUTPUT_OE)
		else $error("serial data low not driven on the shared pin");
	od_level_a: assert property (!SPEED_TACH_OUTPUT_O && !ROTOR_FAULT_O)
		else $error("open-drain output drives high");
	source_gate_a: assert property (!DRIVE_EN |-> !SOURCE_EN)
		else $error("source drivers on while drive is off");
	oc_shut_a: assert property (oc_cnt >= 8'd162 |-> !DRIVE_EN)
		else $error("drive still on after persistent overcurrent");
	lock_stop_a: assert property (ROTOR_LOCKED |-> ##[0:3] !DRIVE_EN)
		else $error("drive not stopped on locked rotor");
	phase_code_a: assert property (PHASE_ORDER == 3'b001 || PHASE_ORDER == 3'b010)
		else $error("phase order code invalid");
endmodule
bind fan_speed_demand_control fan_ctrl_chk fan_ctrl_chk_inst (.CLK(CLK), .NRST(NRST),
	.RD_STB(RD_STB), .RDATA(RDATA), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SDA_IN(SDA_IN),
	.SPEED_TACH_IN(SPEED_TACH_IN), .SPEED_TACH_OUTPUT_O(SPEED_TACH_OUTPUT_O),
	.SPEED_TACH_OUTPUT_OE(SPEED_TACH_OUTPUT_OE), .ROTOR_FAULT_O(ROTOR_FAULT_O),
	.DRIVE_EN(DRIVE_EN), .SOURCE_EN(SOURCE_EN), .DS_OVERCURRENT(DS_OVERCURRENT),
	.ROTOR_LOCKED(ROTOR_LOCKED), .PHASE_ORDER(PHASE_ORDER));

// [verification/tb.sv]
// Purpose: self-checking bench of the fan speed demand block
// Assumes: demand period 2555 cycles, under 100 kHz at 250 MHz
// Notes: whole demand periods are waited so each duty settles
`include "fan_ctrl_params.svh"
module tb;
	import fan_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 2555;
	localparam logic [31:0] PROT = 32'h0001_9048;
	localparam logic [31:0] C0_T [5] = '{32'h0040_43e8, 32'h0040_53e8, 32'h0040_43e8,
		32'h0040_43e8, 32'h0040_03e8};
	localparam logic [31:0] C1_T [5] = '{32'h0, 32'h0, 32'h0064_0000, 32'h0200_0000,
		32'h0200_0000};
	localparam int D_T [5] = '{200, 200, 50, 505, 505};
	localparam logic [15:0] SP_T [5] = '{16'h04b0, 16'h051f, 16'h044c, 16'h05d7, 16'hffff};
	localparam logic [9:0] A_T [3] = '{10'h005, 10'h12c, 10'h3e8};
	localparam logic [31:0] AC_T [3] = '{32'h0, 32'h120, 32'h1ff};
	localparam int H_T [6] = '{30, 0, 75, 120, 75, 30};
	localparam logic [31:0] E_T [6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0};
	logic CLK, NRST, WR, RD_STB, ROTATION_SENSE, ROTOR_LOCKED, ROTOR_FAULT, START_DONE;
	logic ELEC_CYCLE, DS_OVERCURRENT, SINK_OVERCURRENT, PWM_CYCLE_START, SDA_OUT, SDA_OE;
	logic pwm, SDA_IN, TACH_OE, FAULT_OE, DRIVE_EN, SOURCE_EN, REVERSE_SPIN, BRAKE;
	logic [7:0] ADDR;
	logic [31:0] WDATA, RDATA, rv;
	logic [9:0] ADC_RAW;
	logic [2:0] PHASE_ORDER;
	logic [1:0] LIMIT;
	logic [15:0] TARGET, high_cyc;
	int n_mismatch = 0, checks_done = 0, cyc = 0, i, tog;
	wire tach_wire = !TACH_OE;
	demand_host demand_host_inst (.clk(CLK), .nrst(NRST), .high_cyc(high_cyc),
		.period_cyc(16'(PER)), .pwm(pwm));
	fan_speed_demand_control fan_speed_demand_control_inst (.CLK(CLK), .NRST(NRST),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD_STB(RD_STB), .RDATA(RDATA),
		.SPEED_DEMAND_INPUT(pwm), .ADC_RAW(ADC_RAW), .ROTATION_SENSE(ROTATION_SENSE),
		.ROTOR_LOCKED(ROTOR_LOCKED), .ROTOR_FAULT(ROTOR_FAULT), .START_DONE(START_DONE),
		.REVERSE_SPIN(REVERSE_SPIN), .ELEC_CYCLE(ELEC_CYCLE), .DS_OVERCURRENT(DS_OVERCURRENT),
		.SINK_OVERCURRENT(SINK_OVERCURRENT), .PWM_CYCLE_START(PWM_CYCLE_START),
		.SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SDA_IN(SDA_IN), .SPEED_TACH_IN(tach_wire),
		.SPEED_TACH_OUTPUT_O(), .SPEED_TACH_OUTPUT_OE(TACH_OE), .ROTOR_FAULT_O(),
		.ROTOR_FAULT_OE(FAULT_OE), .DRIVE_EN(DRIVE_EN), .SOURCE_EN(SOURCE_EN),
		.BRAKE_RESYNC(BRAKE), .PHASE_ORDER(PHASE_ORDER), .CURRENT_LIMIT_LEVEL(LIMIT),
		.TARGET_SPEED(TARGET));
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CLK);
		RD_STB <= 1'b0;
		@(negedge CLK);
		rv = RDATA;
	endtask
	// slight excess high time keeps the measured duty off a rounding edge
	task automatic duty(int d);
		@(posedge CLK);
		high_cyc <= (d == 0) ? 16'h0 : 16'(5 * d + 2);
		tick(2 * PER + 10);
	endtask
	initial
	begin
		{WR, RD_STB, ROTOR_LOCKED, ROTOR_FAULT, ELEC_CYCLE, DS_OVERCURRENT} = '0;
		{SINK_OVERCURRENT, PWM_CYCLE_START, SDA_OE, NRST, REVERSE_SPIN} = '0;
		{ROTATION_SENSE, START_DONE, SDA_OUT} = 3'b111;
		{ADDR, WDATA, ADC_RAW, high_cyc} = '0;
		tick(2);
		NRST <= 1'b1;
		rd(8'h00);
		cmp("curve0", {2'b00, `RST_SLOPE, 1'b0, `RST_CLAMPOPT, 2'b00, `RST_MINIMUM_SPEED_SETTING}, rv);
		rd(8'h04);
		cmp("curve1", {16'h0, `RST_DISTHR, `RST_ENTHR}, rv);
		rd(8'h0c);
		cmp("lock off time", 32'h3e8, rv);
		rd(8'h20);
		cmp("id", `ID_VALUE, rv);
		cmp("phase order", 32'h1, {29'h0, PHASE_ORDER});
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40);
		cmp("unmapped", 32'h0, rv);
		wr(8'h08, 32'h0);
		wr(8'h0c, 32'h12c);
		wr(8'h10, PROT);
		for (i = 0; i < 5; i++)
		begin
			wr(8'h00, C0_T[i]);
			wr(8'h04, C1_T[i]);
			duty(D_T[i]);
			cmp("target", {16'h0, SP_T[i]}, {16'h0, TARGET});
			rd(8'h14);
			cmp("demand", 32'(D_T[i]), {23'h0, rv[13:5]});
		end
		wr(8'h00, C0_T[0]);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h05dc_0064);
		tick(4);
		cmp("dual slope target", 32'h771, {16'h0, TARGET});
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h0040_c3e8);
		for (i = 0; i < 3; i++)
		begin
			@(posedge CLK);
			ADC_RAW <= A_T[i];
			tick(3);
			rd(8'h1c);
			cmp("analog code", AC_T[i], rv);
		end
		wr(8'h00, 32'h0040_43e8);
		wr(8'h04, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h10, PROT | 32'(i));
			tick(2);
			cmp("limit level", 32'(i), {30'h0, LIMIT});
		end
		wr(8'h10, PROT);
		tick(2);
		cmp("source on", 32'h1, {31'h0, SOURCE_EN});
		SINK_OVERCURRENT <= 1'b1;
		tick(1);
		SINK_OVERCURRENT <= 1'b0;
		tick(20);
		cmp("source cut", 32'h0, {31'h0, SOURCE_EN});
		PWM_CYCLE_START <= 1'b1;
		tick(1);
		PWM_CYCLE_START <= 1'b0;
		tick(3);
		cmp("source back", 32'h1, {31'h0, SOURCE_EN});
		wr(8'h10, PROT | 32'h4);
		SINK_OVERCURRENT <= 1'b1;
		tick(1);
		SINK_OVERCURRENT <= 1'b0;
		tick(3);
		cmp("limit off", 32'h1, {31'h0, SOURCE_EN});
		ROTOR_FAULT <= 1'b1;
		tick(3);
		cmp("fault pin", 32'h0, {31'h0, FAULT_OE});
		ROTOR_FAULT <= 1'b0;
		tick(3);
		cmp("fault pin", 32'h1, {31'h0, FAULT_OE});
		wr(8'h10, PROT | 32'h100);
		tick(3);
		cmp("start end flag", 32'h0, {31'h0, FAULT_OE});
		wr(8'h10, PROT);
		tog = 0;
		for (i = 0; i < 8; i++)
		begin
			ELEC_CYCLE <= 1'b1;
			rv[0] = TACH_OE;
			tick(1);
			ELEC_CYCLE <= 1'b0;
			tick(4);
			if (TACH_OE !== rv[0])
				tog++;
		end
		cmp("tach toggles", 32'h8, 32'(tog));
		SDA_OE <= 1'b1;
		SDA_OUT <= 1'b0;
		tick(3);
		cmp("shared data line", 32'h0, {31'h0, SDA_IN});
		SDA_OE <= 1'b0;
		DS_OVERCURRENT <= 1'b1;
		tick(100);
		DS_OVERCURRENT <= 1'b0;
		tick(3);
		cmp("drive after glitch", 32'h1, {31'h0, DRIVE_EN});
		DS_OVERCURRENT <= 1'b1;
		tick(170);
		DS_OVERCURRENT <= 1'b0;
		cmp("drive in shutdown", 32'h0, {31'h0, DRIVE_EN});
		rd(8'h14);
		cmp("state", 32'(ST_SHUTDOWN), {29'h0, rv[2:0]});
		tick(260);
		rd(8'h14);
		cmp("left shutdown", 32'h1, {31'h0, rv[2:0] !== ST_SHUTDOWN});
		tick(1);
		ROTOR_LOCKED <= 1'b1;
		tick(2);
		ROTOR_LOCKED <= 1'b0;
		tick(200);
		cmp("drive in lock off", 32'h0, {31'h0, DRIVE_EN});
		tick(150);
		cmp("drive restarted", 32'h1, {31'h0, DRIVE_EN});
		ROTATION_SENSE <= 1'b0;
		REVERSE_SPIN <= 1'b1;
		tick(5);
		rd(8'h14);
		cmp("state", 32'(ST_COAST), {29'h0, rv[2:0]});
		tick(260);
		cmp("resync brake", 32'h1, {31'h0, BRAKE});
		REVERSE_SPIN <= 1'b0;
		tick(3);
		rd(8'h14);
		cmp("left coast", 32'h1, {31'h0, rv[2:0] !== ST_COAST});
		cmp("phase order", 32'h2, {29'h0, PHASE_ORDER});
		wr(8'h04, 32'h0000_3264);
		for (i = 0; i < 6; i++)
		begin
			duty(H_T[i]);
			rd(8'h14);
			if (i == 1)
				cmp("state", 32'(ST_STANDBY), {29'h0, rv[2:0]});
			else
				cmp("enabled", E_T[i], {31'h0, rv[3]});
		end
		wr(8'h04, 32'h0);
		duty(0);
		rd(8'h14);
		cmp("no standby", 32'h1, {31'h0, rv[2:0] !== ST_STANDBY});
		summarize();
	end
endmodule
